/* hdl/pio_port.sv */
/*
  Three-port general purpose I/O block with alternate-function steering:
  port zero 8 bits, port one 5 bits, port three bits 1..5.
  Assumes an external pad ring that resolves pin level from out/oe and
  applies the pull-up request; peripherals sit on the same clock.
*/
// Design decision made here: strobed register access.
// Behaviour
// RULE_01 - Port zero is 8-bit bidirectional, data at C0, direction at C1.
// RULE_02 - Each port zero pin has its own direction bit.
// RULE_03 - Direction one means output, zero means input.
// RULE_04 - All pins are inputs after reset.
// RULE_05 - Port zero input pins get pull-ups per bit from its select.
// RULE_06 - Port zero open-drain bit removes active high drive.
// RULE_07 - Select registers at F8 and F9 pick timer, counter, irq functions.
// RULE_08 - Selected alternate function on port zero overrides direction.
// RULE_09 - Port zero map: irq3/serial clock, irq2, counter inputs, timers.
// RULE_10 - Converter, serial and uart functions follow their mode registers.
// RULE_11 - Port one is 5-bit bidirectional, data at C2, direction at C3.
// RULE_12 - Port one has per-bit pull-up and open-drain selects.
// RULE_13 - Selected alternate function on port one overrides direction.
// RULE_14 - Port one map: analog 0/reference/pwm1, irq0/pwm3, irq1/buzzer.
// RULE_15 - Port three is 5-bit, data at C6, direction at C7.
// RULE_16 - Port three bit five is input only and never drives.
// RULE_17 - Port three pull-ups on bits 1..5, open-drain on bits 1..4.
// RULE_18 - Port three bits 1, 2 are analog inputs 14, 15 when selected.
// RULE_19 - Port three bits 3..5 are general I/O only by configuration option.
// RULE_20 - Data reads give pin levels for inputs, latches for outputs.
`timescale 1ns/10ps
`default_nettype none
`include "pio_consts.svh"

module pio_port (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       gpio_opt_p3_hi,
  input  wire logic [7:0] p0_in,
  output logic      [7:0] p0_out,
  output logic      [7:0] p0_oe,
  output logic      [7:0] p0_pullup,
  output logic      [7:0] p0_analog,
  input  wire logic [4:0] p1_in,
  output logic      [4:0] p1_out,
  output logic      [4:0] p1_oe,
  output logic      [4:0] p1_pullup,
  output logic      [4:0] p1_analog,
  input  wire logic [5:1] p3_in,
  output logic      [5:1] p3_out,
  output logic      [5:1] p3_oe,
  output logic      [5:1] p3_pullup,
  output logic      [5:1] p3_analog,
  input  wire logic       timer_zero_out,
  input  wire logic       timer_two_out,
  input  wire logic       pwm_one_out,
  input  wire logic       pwm_three_out,
  input  wire logic       buzzer_out,
  input  wire logic       serial_data_out,
  input  wire logic       serial_clk_out,
  input  wire logic       serial_clk_master,
  input  wire logic       uart_data_out,
  output logic            ext_irq_zero,
  output logic            ext_irq_one,
  output logic            ext_irq_two,
  output logic            ext_irq_three,
  output logic            event_count_in_zero,
  output logic            event_count_in_one,
  output logic            serial_clk_in,
  output logic            serial_data_in,
  output logic            uart_data_in,
  output logic            uart_clk_in,
  output logic            analog_reference_in
);

  pio_pkg::pio_state_t s_q;
  pio_pkg::pio_state_t s_d;

  logic [7:0] alt_en0;
  logic [7:0] alt_oe0;
  logic [7:0] alt_out0;
  logic [4:0] alt_en1;
  logic [4:0] alt_oe1;
  logic [4:0] alt_out1;
  logic [5:1] alt_en3;
  logic       conv_on;
  logic       ser_on;
  logic       uart_on;
  logic [3:0] conv_ch;
  logic [5:1] p3_gpio;

  // Pin drivers: open drain drops the high drive by gating enable.
  function automatic logic drv_oe(input logic oe, input logic od,
                                  input logic val);
    drv_oe = oe & ~(od & val);
  endfunction

  // Read value: latch for output pins, synchronised pin for inputs.
  function automatic logic [7:0] mix_rd(input logic [7:0] dir,
                                        input logic [7:0] lat,
                                        input logic [7:0] pin);
    mix_rd = (dir & lat) | (~dir & pin);
  endfunction

  assign conv_on = s_q.conv_mode[`PIO_CM_EN];
  assign conv_ch = s_q.conv_mode[`PIO_CM_CH_LSB +: 4];
  assign ser_on  = s_q.ser_mode[`PIO_SM_EN];
  assign uart_on = s_q.uart_mode[`PIO_UM_EN];

  // Alternate steering of port zero
  always_comb begin
    alt_en0  = 8'h00;
    alt_oe0  = 8'h00;
    alt_out0 = 8'h00;
    alt_en0[0] = s_q.sel_a[`PIO_SA_EXT_IRQ_THREE] | ser_on; // RULE_09
    alt_oe0[0] = ser_on & serial_clk_master;
    alt_out0[0] = serial_clk_out;
    alt_en0[1] = ser_on; // RULE_10
    alt_en0[2] = ser_on;
    alt_oe0[2] = ser_on;
    alt_out0[2] = serial_data_out;
    alt_en0[3] = s_q.sel_a[`PIO_SA_EXT_IRQ_TWO]; // RULE_07
    alt_en0[4] = s_q.sel_a[`PIO_SA_EC0] | uart_on;
    alt_en0[5] = s_q.sel_b[`PIO_SB_T0] | uart_on; // RULE_09
    alt_oe0[5] = alt_en0[5];
    alt_out0[5] = s_q.sel_b[`PIO_SB_T0] ? timer_zero_out : uart_data_out;
    alt_en0[6] = s_q.sel_b[`PIO_SB_T2] | uart_on;
    alt_oe0[6] = s_q.sel_b[`PIO_SB_T2];
    alt_out0[6] = timer_two_out;
    alt_en0[7] = s_q.sel_a[`PIO_SA_EC1];
  end

  // Alternate steering of port one
  always_comb begin
    alt_en1  = 5'h00;
    alt_oe1  = 5'h00;
    alt_out1 = 5'h00;
    alt_en1[0] = s_q.sel_a[`PIO_SA_PWM1] | s_q.sel_b[`PIO_SB_AREF]; // RULE_14
    alt_oe1[0] = s_q.sel_a[`PIO_SA_PWM1] & ~s_q.sel_b[`PIO_SB_AREF];
    alt_out1[0] = pwm_one_out;
    alt_en1[1] = s_q.sel_a[`PIO_SA_EXT_IRQ_ZERO] | s_q.sel_a[`PIO_SA_PWM3];
    alt_oe1[1] = s_q.sel_a[`PIO_SA_PWM3];
    alt_out1[1] = pwm_three_out;
    alt_en1[2] = s_q.sel_a[`PIO_SA_EXT_IRQ_ONE] | s_q.sel_b[`PIO_SB_BUZ];
    alt_oe1[2] = s_q.sel_b[`PIO_SB_BUZ];
    alt_out1[2] = buzzer_out;
  end

  // Port three: bits 3..5 belong to oscillator and reset unless opted out.
  assign p3_gpio = {{3{gpio_opt_p3_hi}}, 2'b11}; // RULE_19
  assign alt_en3 = {3'b000,
                    conv_on & (conv_ch == 4'hF),
                    conv_on & (conv_ch == 4'hE)}; // RULE_18

  always_comb begin
    s_d = s_q;
    s_d.in0_m = p0_in;
    s_d.in0   = s_q.in0_m;
    s_d.in1_m = p1_in;
    s_d.in1   = s_q.in1_m;
    s_d.in3_m = {p3_in, 1'b0};
    s_d.in3   = s_q.in3_m;
    if (reg_wr) begin
      case (reg_addr)
        `PIO_ADDR_PORT0:     s_d.port0 = reg_wdata; // RULE_01
        `PIO_ADDR_DIR0:      s_d.dir0 = reg_wdata; // RULE_02
        `PIO_ADDR_PORT1:     s_d.port1 = reg_wdata[4:0]; // RULE_11
        `PIO_ADDR_DIR1:      s_d.dir1 = reg_wdata[4:0];
        `PIO_ADDR_PORT3:     s_d.port3 = reg_wdata[5:0]; // RULE_15
        // Bit five stays an input whatever software writes
        `PIO_ADDR_DIR3:      s_d.dir3 = 6'(reg_wdata & `PIO_P3_OD_MASK);
        `PIO_ADDR_ALTSEL_A:  s_d.sel_a = reg_wdata; // RULE_07
        `PIO_ADDR_ALTSEL_B:  s_d.sel_b = reg_wdata[3:0];
        `PIO_ADDR_PU0:       s_d.pu0 = reg_wdata;
        `PIO_ADDR_PU1:       s_d.pu1 = reg_wdata[4:0];
        `PIO_ADDR_PU3:       s_d.pu3 = 6'(reg_wdata & `PIO_P3_PU_MASK);
        `PIO_ADDR_OD0:       s_d.od0 = reg_wdata;
        `PIO_ADDR_OD1:       s_d.od1 = reg_wdata[4:0];
        `PIO_ADDR_OD3:       s_d.od3 = 6'(reg_wdata & `PIO_P3_OD_MASK);
        `PIO_ADDR_CONV_MODE: s_d.conv_mode = reg_wdata;
        `PIO_ADDR_SER_MODE:  s_d.ser_mode = reg_wdata;
        `PIO_ADDR_UART_MODE: s_d.uart_mode = reg_wdata;
        default: ;
      endcase
    end
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `PIO_ADDR_PORT0:
          s_d.rdata = mix_rd(s_q.dir0, s_q.port0, s_q.in0); // RULE_20
        `PIO_ADDR_DIR0:      s_d.rdata = s_q.dir0;
        `PIO_ADDR_PORT1:
          s_d.rdata = mix_rd({3'b000, s_q.dir1}, {3'b000, s_q.port1},
                             {3'b000, s_q.in1}); // RULE_20
        `PIO_ADDR_DIR1:      s_d.rdata = {3'b000, s_q.dir1};
        `PIO_ADDR_PORT3:
          s_d.rdata = mix_rd({2'b00, s_q.dir3}, {2'b00, s_q.port3},
                             {2'b00, s_q.in3}) & `PIO_P3_PU_MASK;
        `PIO_ADDR_DIR3:      s_d.rdata = {2'b00, s_q.dir3};
        `PIO_ADDR_ALTSEL_A:  s_d.rdata = s_q.sel_a;
        `PIO_ADDR_ALTSEL_B:  s_d.rdata = {4'h0, s_q.sel_b};
        `PIO_ADDR_PU0:       s_d.rdata = s_q.pu0;
        `PIO_ADDR_PU1:       s_d.rdata = {3'b000, s_q.pu1};
        `PIO_ADDR_PU3:       s_d.rdata = {2'b00, s_q.pu3};
        `PIO_ADDR_OD0:       s_d.rdata = s_q.od0;
        `PIO_ADDR_OD1:       s_d.rdata = {3'b000, s_q.od1};
        `PIO_ADDR_OD3:       s_d.rdata = {2'b00, s_q.od3};
        `PIO_ADDR_CONV_MODE: s_d.rdata = s_q.conv_mode;
        `PIO_ADDR_SER_MODE:  s_d.rdata = s_q.ser_mode;
        `PIO_ADDR_UART_MODE: s_d.rdata = s_q.uart_mode;
        default:             s_d.rdata = 8'h00;
      endcase
    end
  end

  // Direction and mode registers clear to input at reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0; // RULE_04
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;

  // Port zero pads
  always_comb begin
    logic [7:0] oe0;
    logic [7:0] v0;
    oe0 = 8'h00;
    v0  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      oe0[i] = alt_en0[i] ? alt_oe0[i] : s_q.dir0[i]; // RULE_08
      v0[i]  = alt_en0[i] ? alt_out0[i] : s_q.port0[i]; // RULE_03
      p0_oe[i] = drv_oe(oe0[i], s_q.od0[i], v0[i]); // RULE_06
    end
    p0_out = v0;
    p0_pullup = s_q.pu0 & ~oe0; // RULE_05
    p0_analog = {7{conv_on}} == 7'h00 ? 8'h00 : {(conv_ch == 4'h7),
                (conv_ch == 4'h6), (conv_ch == 4'h5), (conv_ch == 4'h4),
                (conv_ch == 4'h3), (conv_ch == 4'h2), (conv_ch == 4'h1),
                1'b0}; // RULE_10
  end

  // Port one pads
  always_comb begin
    logic [4:0] oe1;
    logic [4:0] v1;
    oe1 = 5'h00;
    v1  = 5'h00;
    for (int i = 0; i < 5; i++) begin
      oe1[i] = alt_en1[i] ? alt_oe1[i] : s_q.dir1[i]; // RULE_13
      v1[i]  = alt_en1[i] ? alt_out1[i] : s_q.port1[i];
      p1_oe[i] = drv_oe(oe1[i], s_q.od1[i], v1[i]); // RULE_12
    end
    p1_out = v1;
    p1_pullup = s_q.pu1 & ~oe1; // RULE_12
    p1_analog = {4'h0, (conv_on & (conv_ch == 4'h0)) |
                 s_q.sel_b[`PIO_SB_AREF]}; // RULE_14
  end

  // Port three pads; bit five never drives.
  always_comb begin
    logic [5:1] oe3;
    oe3 = 5'h00;
    for (int i = 1; i < 6; i++) begin
      oe3[i] = s_q.dir3[i] & ~alt_en3[i] & p3_gpio[i] & (i != 5); // RULE_16
      p3_oe[i] = drv_oe(oe3[i], s_q.od3[i], s_q.port3[i]); // RULE_17
    end
    p3_out = s_q.port3[5:1];
    p3_pullup = s_q.pu3[5:1] & ~oe3 & p3_gpio; // RULE_17
    p3_analog = alt_en3; // RULE_18
  end

  // Alternate inputs come from the synchronised pins; analog_reference_in comes from the select B bit alone.
  assign ext_irq_three       = s_q.sel_a[`PIO_SA_EXT_IRQ_THREE] & s_q.in0[0];
  assign serial_clk_in       = ser_on & s_q.in0[0];
  assign serial_data_in      = ser_on & s_q.in0[1];
  assign ext_irq_two         = s_q.sel_a[`PIO_SA_EXT_IRQ_TWO] & s_q.in0[3];
  assign event_count_in_zero = s_q.sel_a[`PIO_SA_EC0] & s_q.in0[4];
  assign uart_data_in        = uart_on & s_q.in0[4];
  assign uart_clk_in         = uart_on & s_q.in0[6];
  assign event_count_in_one  = s_q.sel_a[`PIO_SA_EC1] & s_q.in0[7];
  assign ext_irq_zero        = s_q.sel_a[`PIO_SA_EXT_IRQ_ZERO] & s_q.in1[1];
  assign ext_irq_one         = s_q.sel_a[`PIO_SA_EXT_IRQ_ONE] & s_q.in1[2];
  assign analog_reference_in = s_q.sel_b[`PIO_SB_AREF];

endmodule

`default_nettype wire

/* hdl/pio_consts.svh */
/*
  Register offsets, field positions and reset values of the port block.
  Assumes an 8-bit register port with byte addresses.
*/
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

`define PIO_ADDR_PORT0      8'hC0
`define PIO_ADDR_DIR0       8'hC1
`define PIO_ADDR_PORT1      8'hC2
`define PIO_ADDR_DIR1       8'hC3
`define PIO_ADDR_PORT3      8'hC6
`define PIO_ADDR_DIR3       8'hC7
`define PIO_ADDR_ALTSEL_A   8'hF8
`define PIO_ADDR_ALTSEL_B   8'hF9
`define PIO_ADDR_PU0        8'hFC
`define PIO_ADDR_PU1        8'hFD
`define PIO_ADDR_PU3        8'hFF
`define PIO_ADDR_OD0        8'hD0
`define PIO_ADDR_OD1        8'hD1
`define PIO_ADDR_OD3        8'hD3
`define PIO_ADDR_CONV_MODE  8'hEF
`define PIO_ADDR_SER_MODE   8'hE2
`define PIO_ADDR_UART_MODE  8'hE6

`define PIO_RST_BYTE        8'h00
`define PIO_MASK5           8'h1F
`define PIO_P3_OD_MASK      8'h1E
`define PIO_P3_PU_MASK      8'h3E

// Alternate select A fields
`define PIO_SA_EXT_IRQ_ZERO         0
`define PIO_SA_EXT_IRQ_ONE         1
`define PIO_SA_EXT_IRQ_TWO         2
`define PIO_SA_EXT_IRQ_THREE         3
`define PIO_SA_EC0          4
`define PIO_SA_EC1          5
`define PIO_SA_PWM1         6
`define PIO_SA_PWM3         7
// Alternate select B fields
`define PIO_SB_T0           0
`define PIO_SB_T2           1
`define PIO_SB_BUZ          2
`define PIO_SB_AREF         3
// Converter mode fields
`define PIO_CM_EN           7
`define PIO_CM_CH_LSB       2
// Serial and uart mode enable bits
`define PIO_SM_EN           0
`define PIO_UM_EN           0

`endif

/* hdl/pio_pkg.sv */
/*
  Types of the port block.
  Assumes pio_consts.svh for the numbers.
*/
package pio_pkg;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] dir0;
    logic [4:0] port1;
    logic [4:0] dir1;
    logic [5:0] port3;
    logic [5:0] dir3;
    logic [7:0] sel_a;
    logic [3:0] sel_b;
    logic [7:0] pu0;
    logic [4:0] pu1;
    logic [5:0] pu3;
    logic [7:0] od0;
    logic [4:0] od1;
    logic [5:0] od3;
    logic [7:0] conv_mode;
    logic [7:0] ser_mode;
    logic [7:0] uart_mode;
    logic [7:0] rdata;
    logic [7:0] in0_m;
    logic [7:0] in0;
    logic [4:0] in1_m;
    logic [4:0] in1;
    logic [5:0] in3_m;
    logic [5:0] in3;
  } pio_state_t;

endpackage

/* verif/pio_port_assertions.sv */
/* Checker of the port block's register port and pin enables.
   Assumes binding to pio_port with the register map of pio_consts.svh. */
`timescale 1ns/10ps
`default_nettype none
`include "pio_consts.svh"
module pio_port_assertions (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p0_pullup,
  input wire logic [4:0] p1_oe,
  input wire logic [4:0] p1_pullup,
  input wire logic [5:1] p3_oe,
  input wire logic [5:1] p3_pullup,
  input wire logic       ext_irq_two,
  input wire logic       ext_irq_three,
  input wire logic       event_count_in_zero
);
  // Shadow copies of the registers whose effect is watched
  logic [7:0] dir0_q;
  logic [7:0] sela_q;
  logic [3:0] selb_q;
  // Open drain on the timer pin legally releases a high level
  logic       od5_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir0_q <= 8'h00;
      sela_q <= 8'h00;
      selb_q <= 4'h0;
      od5_q  <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `PIO_ADDR_DIR0) dir0_q <= reg_wdata;
      if (reg_addr == `PIO_ADDR_ALTSEL_A) sela_q <= reg_wdata;
      if (reg_addr == `PIO_ADDR_ALTSEL_B) selb_q <= reg_wdata[3:0];
      if (reg_addr == `PIO_ADDR_OD0) od5_q <= reg_wdata[5];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  reset_input_a: assert property (
    $rose(reset_n) |-> {p0_oe, p1_oe, p3_oe} == 18'h0)
    else $error("pin driven after reset");
  input_only_a: assert property (
    p3_oe[5] == 1'b0) else $error("input-only pin driven");
  pullup_off_a: assert property (
    ((p0_pullup & p0_oe) | {3'h0, p1_pullup & p1_oe}
     | {3'h0, p3_pullup & p3_oe}) == 8'h00) else $error("pull-up on output");
  dir_readback_a: assert property (
    s_rd(`PIO_ADDR_DIR0) |=> reg_rdata == $past(dir0_q))
    else $error("direction readback wrong");
  unmapped_rd_a: assert property (
    reg_rd && !reg_addr[7] |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  narrow_one_a: assert property (
    reg_rd && reg_addr inside {8'hC2, 8'hC3} |=> reg_rdata[7:5] == 3'h0)
    else $error("port one high bits set");
  narrow_three_a: assert property (
    s_rd(`PIO_ADDR_DIR3) |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[0])
    else $error("port three spare bits set");
  alt_gate_a: assert property (
    ((~sela_q & ~$past(sela_q) & ~$past(sela_q, 2)) & {3'h0,
      event_count_in_zero, ext_irq_three, ext_irq_two, 2'h0}) == 8'h00)
    else $error("unselected function active");
  timer_oe_a: assert property (
    selb_q[0] && $past(selb_q[0]) && !od5_q |-> p0_oe[5])
    else $error("timer output not driven");
endmodule
bind pio_port pio_port_assertions u_chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .p0_oe(p0_oe), .p0_pullup(p0_pullup),
  .p1_oe(p1_oe), .p1_pullup(p1_pullup), .p3_oe(p3_oe),
  .p3_pullup(p3_pullup), .ext_irq_two(ext_irq_two),
  .ext_irq_three(ext_irq_three),
  .event_count_in_zero(event_count_in_zero)
);
`default_nettype wire

/* verif/pio_pin_model.sv */
/* Pad and board model: resolves each pin from drive, pull-up and the
   far side, which releases a line by driving it high. */
`timescale 1ns/10ps
`default_nettype none
module pio_pin_model (
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe,
  input  wire logic [7:0] p0_pu,
  input  wire logic [7:0] p0_ext,
  input  wire logic [4:0] p1_out,
  input  wire logic [4:0] p1_oe,
  input  wire logic [4:0] p1_pu,
  input  wire logic [4:0] p1_ext,
  input  wire logic [5:1] p3_out,
  input  wire logic [5:1] p3_oe,
  input  wire logic [5:1] p3_pu,
  input  wire logic [5:1] p3_ext,
  output logic      [7:0] p0_in,
  output logic      [4:0] p1_in,
  output logic      [5:1] p3_in
);
  // Pull-up wins even where the far side pulls low; only the pin's own drive overrides it
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & (p0_pu | p0_ext));
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & (p1_pu | p1_ext));
  assign p3_in = (p3_oe & p3_out) | (~p3_oe & (p3_pu | p3_ext));
endmodule
`default_nettype wire

/* verif/test_pio_port.sv */
/* Self-checking bench of the port block over its register port.
   Assumes pio_pin_model for the pins and the checker bound to uut. */
`timescale 1ns/10ps
`default_nettype none
`include "pio_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_pio_port;
  logic       clk, reset_n, wr, rd, opt, irq2, irq3, ec0, aref;
  logic [7:0] addr, wdata, rdata, p0_out, p0_oe, p0_pu, p0_in, p0_ext, an0;
  logic [4:0] p1_out, p1_oe, p1_pu, p1_in, p1_ext, an1;
  logic [5:1] p3_out, p3_oe, p3_pu, p3_in, p3_ext, an3;
  logic [8:0] per;
  int         num_errors, checks;
  logic [7:0] ra [8] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC6, 8'hC7, 8'hF8,
                         8'hF9};
  logic [7:0] rv [8] = '{8'hA3, 8'h00, 8'h0A, 8'h00, 8'h20, 8'h00, 8'h00,
                         8'h00};
  pio_port uut (
    .clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .gpio_opt_p3_hi(opt),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pu),
    .p0_analog(an0), .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe),
    .p1_pullup(p1_pu), .p1_analog(an1), .p3_in(p3_in), .p3_out(p3_out),
    .p3_oe(p3_oe), .p3_pullup(p3_pu), .p3_analog(an3),
    .timer_zero_out(per[0]), .timer_two_out(per[1]), .pwm_one_out(per[2]),
    .pwm_three_out(per[3]), .buzzer_out(per[4]), .serial_data_out(per[5]),
    .serial_clk_out(per[6]), .serial_clk_master(per[7]),
    .uart_data_out(per[8]), .ext_irq_zero(), .ext_irq_one(),
    .ext_irq_two(irq2), .ext_irq_three(irq3), .event_count_in_zero(ec0),
    .event_count_in_one(), .serial_clk_in(), .serial_data_in(),
    .uart_data_in(), .uart_clk_in(), .analog_reference_in(aref)
  );
  pio_pin_model u_pins (
    .p0_out(p0_out), .p0_oe(p0_oe), .p0_pu(p0_pu), .p0_ext(p0_ext),
    .p1_out(p1_out), .p1_oe(p1_oe), .p1_pu(p1_pu), .p1_ext(p1_ext),
    .p3_out(p3_out), .p3_oe(p3_oe), .p3_pu(p3_pu), .p3_ext(p3_ext),
    .p0_in(p0_in), .p1_in(p1_in), .p3_in(p3_in)
  );
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Covers the two-flop input synchroniser with margin
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    {reset_n, addr, wdata, wr, rd, num_errors, checks} = '0;
    {opt, per, p0_ext, p1_ext, p3_ext} = {1'b1, 9'h001, 8'hA3, 5'h0A, 5'h10};
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // Pin levels need the synchroniser to fill before the first port read
    settle();
    for (int i = 0; i < 8; i++) rd_chk(ra[i], rv[i]);
    `CHK({p0_oe, p1_oe, p3_oe}, 18'h0)
    $display("test reset done");
    wr_reg(`PIO_ADDR_DIR0, 8'h55);
    wr_reg(`PIO_ADDR_PORT0, 8'h0F);
    settle();
    `CHK(p0_oe, 8'h55)
    `CHK(p0_out & 8'h55, 8'h05)
    rd_chk(`PIO_ADDR_PORT0, 8'hA7);
    rd_chk(`PIO_ADDR_DIR0, 8'h55);
    $display("test direction done");
    wr_reg(`PIO_ADDR_DIR0, 8'h0F);
    wr_reg(`PIO_ADDR_PU0, 8'hF0);
    @(posedge clk) p0_ext <= 8'h00;
    settle();
    `CHK(p0_pu, 8'hF0)
    rd_chk(`PIO_ADDR_PORT0, 8'hFF);
    wr_reg(`PIO_ADDR_DIR0, 8'hFF);
    settle();
    `CHK(p0_pu, 8'h00)
    wr_reg(`PIO_ADDR_PORT0, 8'h3C);
    wr_reg(`PIO_ADDR_OD0, 8'h0F);
    settle();
    `CHK(p0_oe, 8'hF3)
    wr_reg(`PIO_ADDR_OD0, 8'h00);
    wr_reg(`PIO_ADDR_DIR0, 8'h00);
    $display("test pull-up and open-drain done");
    wr_reg(`PIO_ADDR_ALTSEL_B, 8'h03);
    settle();
    `CHK(p0_oe & 8'h60, 8'h60)
    `CHK(p0_out[6:5], 2'b01)
    wr_reg(`PIO_ADDR_ALTSEL_B, 8'h00);
    @(posedge clk) p0_ext <= 8'h19;
    wr_reg(`PIO_ADDR_ALTSEL_A, 8'h1C);
    settle();
    `CHK({irq3, irq2, ec0}, 3'b111)
    @(posedge clk) p0_ext <= 8'h11;
    settle();
    `CHK({irq3, irq2, ec0}, 3'b101)
    wr_reg(`PIO_ADDR_ALTSEL_A, 8'h00);
    settle();
    `CHK({irq3, irq2, ec0}, 3'b000)
    $display("test alternate done");
    wr_reg(`PIO_ADDR_DIR1, 8'hFF);
    wr_reg(`PIO_ADDR_PORT1, 8'h15);
    settle();
    `CHK({p1_oe, p1_out}, 10'h3F5)
    rd_chk(`PIO_ADDR_DIR1, 8'h1F);
    wr_reg(`PIO_ADDR_OD1, 8'h01);
    settle();
    `CHK(p1_oe, 5'h1E)
    rd_chk(`PIO_ADDR_PORT1, 8'h15);
    $display("test port one done");
    wr_reg(`PIO_ADDR_DIR1, 8'h00);
    wr_reg(`PIO_ADDR_ALTSEL_B, 8'h04);
    settle();
    `CHK({p1_oe[2], p1_out[2]}, 2'b10)
    wr_reg(`PIO_ADDR_ALTSEL_B, 8'h08);
    settle();
    `CHK({aref, an1, p1_oe[0]}, 7'h42)
    wr_reg(`PIO_ADDR_ALTSEL_B, 8'h00);
    wr_reg(`PIO_ADDR_CONV_MODE, 8'hB8);
    settle();
    `CHK({an3, an0}, 13'h0100)
    wr_reg(`PIO_ADDR_CONV_MODE, 8'h84);
    settle();
    `CHK({an3, an0}, 13'h0002)
    wr_reg(`PIO_ADDR_CONV_MODE, 8'h00);
    wr_reg(`PIO_ADDR_SER_MODE, 8'h01);
    settle();
    `CHK({p0_oe[2], p0_out[2]}, 2'b10)
    wr_reg(`PIO_ADDR_SER_MODE, 8'h00);
    $display("test analog and serial done");
    wr_reg(`PIO_ADDR_PU3, 8'h3F);
    settle();
    `CHK(p3_pu, 5'h1F)
    wr_reg(`PIO_ADDR_DIR3, 8'hFF);
    wr_reg(`PIO_ADDR_PORT3, 8'hFF);
    settle();
    `CHK(p3_oe, 5'h0F)
    rd_chk(`PIO_ADDR_DIR3, 8'h1E);
    rd_chk(`PIO_ADDR_PORT3, 8'h3E);
    @(posedge clk) opt <= 1'b0;
    settle();
    `CHK(p3_oe, 5'h03)
    wr_reg(`PIO_ADDR_DIR3, 8'h02);
    settle();
    `CHK(p3_oe, 5'h01)
    wr_reg(8'h10, 8'hFF);
    rd_chk(8'h10, 8'h00);
    $display("test port three done");
    complete_run();
  end
endmodule
`default_nettype wire
